// file: core/fcdsp_pkg.sv
// Purpose: Shared constants and types for the caller data serial port.
// Assumes: 40 MHz core clock, 1200 baud asynchronous words.
// Notes: Times are kept in their own units and converted to cycles here.
package fcdsp_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned BAUD = 1200;
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
    localparam int unsigned HALF_CYC = BIT_CYC / 2;
    localparam int unsigned CD_QUAL_MS = 3;
    localparam int unsigned CD_DROP_MS = 10;
    localparam int unsigned CD_QUAL_CYC = CLK_HZ / 1000 * CD_QUAL_MS;
    localparam int unsigned CD_DROP_CYC = CLK_HZ / 1000 * CD_DROP_MS;
    localparam int unsigned DATA_BITS = 8;
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [1:0] {
        FCDSP_IDLE = 2'b00,
        FCDSP_START = 2'b01,
        FCDSP_DATA = 2'b10,
        FCDSP_STOP = 2'b11
    } fcdsp_rx_state_t;

    typedef struct packed {
        logic data;
        logic clk_out;
        logic clk_oe;
        logic ready_out;
        logic ready_oe;
        logic cd_out;
        logic cd_oe;
    } fcdsp_pins_t;
endpackage : fcdsp_pkg

// file: core/fcdsp_core.sv
// Purpose: Serial back end of a 1200 baud FSK caller data receiver.
// Assumes: Demodulated bits and filter activity arrive asynchronously.
// Notes: Ready and carrier pins drive only low in stream mode; enables mark active drive.
`timescale 1ns/1ps
module fcdsp_core #(
    // Counts are parameters only so a bench may shrink them.
    parameter int unsigned BIT_CYC = fcdsp_pkg::BIT_CYC,
    parameter int unsigned HALF_CYC = fcdsp_pkg::HALF_CYC,
    parameter int unsigned QUAL_CYC = fcdsp_pkg::CD_QUAL_CYC,
    parameter int unsigned DROP_CYC = fcdsp_pkg::CD_DROP_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic mode_select,
    input wire logic sleep_request,
    input wire logic demod_bit,
    input wire logic band_activity,
    input wire logic shift_clock_in,
    output fcdsp_pkg::fcdsp_pins_t pins_ff
);
    logic [1:0] mode_sy_ff, sleep_sy_ff, bit_sy_ff, act_sy_ff, sck_sy_ff;
    logic sck_old_ff, bit_old_ff;
    logic mode, sleep, rxb, act, sck_rise;
    fcdsp_pkg::fcdsp_rx_state_t st_ff;
    logic [15:0] bit_cnt_ff;
    logic [3:0] idx_ff;
    logic [7:0] rx_ff, sh_ff;
    logic [3:0] rd_cnt_ff;
    logic [21:0] qual_ff, drop_ff;
    logic cd_ff;
    logic [15:0] rdy_cnt_ff;
    logic rdy_ff;
    logic [15:0] sck_cnt_ff;
    logic word_done, mid, cmp_half;

    always_ff @(posedge core_clk) begin
        mode_sy_ff <= {mode_sy_ff[0], mode_select};
        sleep_sy_ff <= {sleep_sy_ff[0], sleep_request};
        bit_sy_ff <= {bit_sy_ff[0], demod_bit};
        act_sy_ff <= {act_sy_ff[0], band_activity};
        sck_sy_ff <= {sck_sy_ff[0], shift_clock_in};
        sck_old_ff <= sck_sy_ff[1];
        bit_old_ff <= bit_sy_ff[1];
    end
    assign mode = mode_sy_ff[1];
    assign sleep = sleep_sy_ff[1];
    assign rxb = bit_sy_ff[1];
    assign act = act_sy_ff[1];
    assign sck_rise = mode && sck_sy_ff[1] && !sck_old_ff;
    assign mid = bit_cnt_ff == 16'(HALF_CYC);
    assign cmp_half = bit_cnt_ff == 16'(BIT_CYC - 1);

    // Qualification and hysteresis counters for carrier detection.
    always_ff @(posedge core_clk) begin
        if (reset || sleep) begin
            qual_ff <= '0;
            drop_ff <= '0;
            cd_ff <= 1'b0;
        end else if (act) begin
            drop_ff <= '0;
            if (qual_ff >= 22'(QUAL_CYC - 1)) begin
                cd_ff <= 1'b1;
            end else begin
                qual_ff <= qual_ff + 22'd1;
            end
        end else if (cd_ff) begin
            if (drop_ff >= 22'(DROP_CYC - 1)) begin
                cd_ff <= 1'b0;
                qual_ff <= '0;
            end else begin
                drop_ff <= drop_ff + 22'd1;
            end
        end else begin
            qual_ff <= '0;
        end
    end

    // Receive framer; a falling edge while idle resynchronises timing.
    always_ff @(posedge core_clk) begin
        if (reset || sleep || !cd_ff) begin
            st_ff <= fcdsp_pkg::FCDSP_IDLE;
            bit_cnt_ff <= '0;
            idx_ff <= '0;
            rx_ff <= fcdsp_pkg::BYTE_RST;
        end else begin
            unique case (st_ff)
                fcdsp_pkg::FCDSP_IDLE: begin
                    bit_cnt_ff <= '0;
                    if (bit_old_ff && !rxb) begin
                        st_ff <= fcdsp_pkg::FCDSP_START;
                    end
                end
                fcdsp_pkg::FCDSP_START: begin
                    bit_cnt_ff <= cmp_half ? '0 : bit_cnt_ff + 16'd1;
                    if (mid && rxb) begin
                        st_ff <= fcdsp_pkg::FCDSP_IDLE;
                    end else if (cmp_half) begin
                        st_ff <= fcdsp_pkg::FCDSP_DATA;
                        idx_ff <= '0;
                    end
                end
                fcdsp_pkg::FCDSP_DATA: begin
                    bit_cnt_ff <= cmp_half ? '0 : bit_cnt_ff + 16'd1;
                    if (mid) begin
                        rx_ff <= {rxb, rx_ff[7:1]};
                    end
                    if (cmp_half) begin
                        idx_ff <= idx_ff + 4'd1;
                        if (idx_ff == 4'(fcdsp_pkg::DATA_BITS - 1)) begin
                            st_ff <= fcdsp_pkg::FCDSP_STOP;
                        end
                    end
                end
                fcdsp_pkg::FCDSP_STOP: begin
                    bit_cnt_ff <= bit_cnt_ff + 16'd1;
                    if (mid) begin
                        st_ff <= fcdsp_pkg::FCDSP_IDLE;
                    end
                end
            endcase
        end
    end
    assign word_done = st_ff == fcdsp_pkg::FCDSP_STOP && mid;

    // Buffered byte; first received bit leaves first.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sh_ff <= fcdsp_pkg::BYTE_RST;
            rd_cnt_ff <= '0;
        end else if (mode && word_done) begin
            sh_ff <= rx_ff;
            rd_cnt_ff <= '0;
        end else if (sck_rise && rd_cnt_ff < 4'(fcdsp_pkg::DATA_BITS)) begin
            sh_ff <= {1'b1, sh_ff[7:1]};
            rd_cnt_ff <= rd_cnt_ff + 4'd1;
        end
    end

    // Word ready pulse lasts half a bit unless the host clock ends it.
    always_ff @(posedge core_clk) begin
        if (reset || sleep) begin
            rdy_ff <= 1'b0;
            rdy_cnt_ff <= '0;
        end else if (word_done) begin
            rdy_ff <= 1'b1;
            rdy_cnt_ff <= '0;
        end else if (rdy_ff) begin
            rdy_cnt_ff <= rdy_cnt_ff + 16'd1;
            if (sck_rise || rdy_cnt_ff == 16'(HALF_CYC - 1)) begin
                rdy_ff <= 1'b0;
            end
        end
    end

    // Stream clock: low from each data bit start, rising at its centre.
    // A shift register clocked on the rise then takes a settled bit.
    always_ff @(posedge core_clk) begin
        if (reset || sleep || !cd_ff) begin
            sck_cnt_ff <= '0;
        end else if (st_ff == fcdsp_pkg::FCDSP_DATA && bit_cnt_ff == '0) begin
            sck_cnt_ff <= 16'(HALF_CYC - 1);
        end else if (sck_cnt_ff != '0) begin
            sck_cnt_ff <= sck_cnt_ff - 16'd1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset || sleep) begin
            pins_ff <= '{data: 1'b1, clk_out: 1'b1, clk_oe: 1'b0,
                         ready_out: 1'b1, ready_oe: 1'b0,
                         cd_out: 1'b1, cd_oe: 1'b0};
            pins_ff.clk_oe <= !mode;
            pins_ff.ready_oe <= mode;
            pins_ff.cd_oe <= mode;
        end else if (!mode) begin
            pins_ff.data <= cd_ff ? rxb : 1'b1;
            pins_ff.clk_out <= sck_cnt_ff == '0;
            pins_ff.clk_oe <= 1'b1;
            pins_ff.ready_out <= 1'b0;
            pins_ff.ready_oe <= rdy_ff;
            pins_ff.cd_out <= 1'b0;
            pins_ff.cd_oe <= cd_ff;
        end else begin
            pins_ff.data <= sh_ff[0];
            pins_ff.clk_out <= 1'b1;
            pins_ff.clk_oe <= 1'b0;
            pins_ff.ready_out <= !rdy_ff;
            pins_ff.ready_oe <= 1'b1;
            pins_ff.cd_out <= !cd_ff;
            pins_ff.cd_oe <= 1'b1;
        end
    end

    property p_ready_len;
        @(posedge core_clk) disable iff (reset || sleep)
        $rose(rdy_ff) |-> (rdy_ff || mode)[*8];
    endproperty
    a_ready_len: assert property (p_ready_len)
        else $error("Word ready pulse too short.");
    property p_ready_clear;
        @(posedge core_clk) disable iff (reset || sleep)
        rdy_ff && sck_rise && !word_done |=> !rdy_ff;
    endproperty
    a_ready_clear: assert property (p_ready_clear)
        else $error("Word ready not cleared by host clock.");
    property p_nocd_data;
        @(posedge core_clk) disable iff (reset || sleep)
        !mode && !cd_ff |=> pins_ff.data;
    endproperty
    a_nocd_data: assert property (p_nocd_data)
        else $error("Data not high without carrier.");
    property p_withhold;
        @(posedge core_clk) disable iff (reset)
        !cd_ff |=> st_ff == fcdsp_pkg::FCDSP_IDLE;
    endproperty
    a_withhold: assert property (p_withhold)
        else $error("Framer ran without carrier.");
    property p_extra_ignored;
        @(posedge core_clk) disable iff (reset)
        sck_rise && rd_cnt_ff == 4'd8 && !word_done |=> $stable(sh_ff);
    endproperty
    a_extra_ignored: assert property (p_extra_ignored)
        else $error("Extra host clock moved the byte.");
    property p_sleep_quiet;
        @(posedge core_clk) sleep |=> !cd_ff && !rdy_ff;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("Activity during sleep.");
    property p_load;
        @(posedge core_clk) disable iff (reset)
        mode && word_done |=> sh_ff == $past(rx_ff) && rd_cnt_ff == 4'd0;
    endproperty
    a_load: assert property (p_load)
        else $error("Byte not loaded at end of word.");
    property p_cd_drop;
        @(posedge core_clk) disable iff (reset || sleep)
        cd_ff && !act |=> cd_ff || $past(drop_ff) == 22'(DROP_CYC - 1);
    endproperty
    a_cd_drop: assert property (p_cd_drop)
        else $error("Carrier dropped without hysteresis.");
    c_word: cover property (@(posedge core_clk) word_done);
    c_clear: cover property (@(posedge core_clk) rdy_ff && sck_rise);
    c_cd: cover property (@(posedge core_clk) $rose(cd_ff));
endmodule : fcdsp_core

// file: test/fcdsp_host_model.sv
// Purpose: Behavioural host that listens to the stream or reads the buffer.
// Assumes: Wire level is the driven value when enabled, else pulled high.
// Notes: The host clock stands still low outside read bursts.
`timescale 1ns/1ps
module fcdsp_host_model (
    input wire fcdsp_pkg::fcdsp_pins_t pins,
    input wire logic mode_select,
    output logic host_clk,
    output logic [7:0] got_byte,
    output int pulses
);
    logic clk_wire;
    assign clk_wire = pins.clk_oe ? pins.clk_out : 1'b1;
    initial begin
        host_clk = 1'b0;
        got_byte = 8'h00;
        pulses = 0;
    end
    // A shift register takes the data pin on the rise at each bit centre.
    always @(posedge clk_wire) begin
        if (!mode_select) begin
            got_byte = {pins.data, got_byte[7:1]};
            pulses = pulses + 1;
        end
    end
    task clear();
        got_byte = 8'h00;
        pulses = 0;
    endtask : clear
    // Eight read pulses at a 200 ns period, bit taken before each rise.
    task read_byte();
        for (int i = 0; i < 8; i++) begin
            got_byte = {pins.data, got_byte[7:1]};
            host_clk = 1'b1;
            #100;
            host_clk = 1'b0;
            #100;
        end
    endtask : read_byte
endmodule : fcdsp_host_model

// file: test/fsk_caller_data_serial_port_bench.sv
// Purpose: Self-checking bench for the caller data serial port.
// Assumes: Shortened bit and carrier counts are passed as parameters.
// Notes: Scaled counts keep the run short; half bit stays half a bit.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module fsk_caller_data_serial_port_bench;
    localparam int unsigned BIT = 240;
    localparam int unsigned HALF = BIT / 2;
    localparam int unsigned QUAL = 480;
    localparam int unsigned DROP = 1600;
    logic core_clk, reset, mode_select, sleep_request;
    logic demod_bit, band_activity, host_clk;
    logic [7:0] got_byte;
    int pulses, err_total, checks_done, low_cnt;
    fcdsp_pkg::fcdsp_pins_t pins;
    logic rdy_w, cd_w;
    assign rdy_w = pins.ready_oe ? pins.ready_out : 1'b1;
    assign cd_w = pins.cd_oe ? pins.cd_out : 1'b1;
    fcdsp_core #(.BIT_CYC(BIT), .HALF_CYC(HALF), .QUAL_CYC(QUAL),
        .DROP_CYC(DROP)) DUT (.core_clk(core_clk), .reset(reset),
        .mode_select(mode_select), .sleep_request(sleep_request),
        .demod_bit(demod_bit), .band_activity(band_activity),
        .shift_clock_in(host_clk), .pins_ff(pins));
    fcdsp_host_model host (.pins(pins), .mode_select(mode_select),
        .host_clk(host_clk), .got_byte(got_byte), .pulses(pulses));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (!rdy_w) low_cnt++;
    end
    task give_verdict();
        if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task wait_cd_low(output int n);
        for (n = 0; cd_w !== 1'b0; n++) begin
            if (n > QUAL + 20) begin
                err_total++;
                give_verdict();
            end
            @(negedge core_clk);
        end
    endtask : wait_cd_low
    // Start space, eight bits LSB first, stop mark.
    task send_word(input logic [7:0] b);
        logic [9:0] w;
        w = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            demod_bit = w[i];
            repeat (BIT) @(negedge core_clk);
        end
    endtask : send_word
    task t_idle_and_carrier();
        int n;
        `CHK(pins.data, 1'b1)
        `CHK({rdy_w, cd_w, pins.ready_oe}, 3'b110)
        demod_bit = 1'b0;
        band_activity = 1'b1;
        repeat (QUAL / 2) @(negedge core_clk);
        `CHK({cd_w, pins.data}, 2'b11)
        wait_cd_low(n);
        `CHK(n + QUAL / 2 >= QUAL, 1'b1)
        `CHK(pins.data, 1'b0)
        demod_bit = 1'b1;
        repeat (BIT) @(negedge core_clk);
    endtask : t_idle_and_carrier
    task t_stream();
        host.clear();
        low_cnt = 0;
        send_word(8'hA5);
        repeat (BIT) @(negedge core_clk);
        `CHK(pulses, 8)
        `CHK(got_byte, 8'hA5)
        `CHK(low_cnt, HALF)
    endtask : t_stream
    task t_buffered();
        int n;
        logic d;
        mode_select = 1'b1;
        repeat (10) @(negedge core_clk);
        `CHK({rdy_w, pins.ready_oe, pins.clk_oe}, 3'b110)
        fork
            send_word(8'h3C);
            begin
                for (n = 0; rdy_w !== 1'b0; n++) begin
                    if (n > 11 * BIT) begin
                        err_total++;
                        give_verdict();
                    end
                    @(negedge core_clk);
                end
                host.read_byte();
                `CHK(rdy_w, 1'b1)
                `CHK(got_byte, 8'h3C)
            end
        join
        d = pins.data;
        host.read_byte();
        `CHK(got_byte, {8{d}})
    endtask : t_buffered
    task t_carrier_drop();
        int n;
        band_activity = 1'b0;
        repeat (DROP / 2) @(negedge core_clk);
        `CHK(cd_w, 1'b0)
        band_activity = 1'b1;
        repeat (10) @(negedge core_clk);
        band_activity = 1'b0;
        for (n = 0; cd_w !== 1'b1; n++) begin
            if (n > DROP + 20) begin
                err_total++;
                give_verdict();
            end
            @(negedge core_clk);
        end
        `CHK(n >= DROP, 1'b1)
        band_activity = 1'b1;
        wait_cd_low(n);
        `CHK(n >= QUAL, 1'b1)
    endtask : t_carrier_drop
    task t_sleep();
        sleep_request = 1'b1;
        repeat (10) @(negedge core_clk);
        `CHK({cd_w, rdy_w}, 2'b11)
        sleep_request = 1'b0;
    endtask : t_sleep
    initial begin
        err_total = 0;
        checks_done = 0;
        low_cnt = 0;
        reset = 1'b1;
        mode_select = 1'b0;
        sleep_request = 1'b0;
        demod_bit = 1'b1;
        band_activity = 1'b0;
        repeat (4) @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(negedge core_clk);
        t_idle_and_carrier();
        t_stream();
        t_buffered();
        t_carrier_drop();
        t_sleep();
        give_verdict();
    end
endmodule : fsk_caller_data_serial_port_bench
